// [core/vim_pkg.sv]
// Package: constants, types and register map of the vectored interrupt mux
package vim_pkg;
  // --------------------------------------------------
  // Sizes
  // --------------------------------------------------
  localparam int NUM_IRQ = 32;
  localparam int NUM_SYS = 16;
  localparam int NUM_EXC = 48;
  localparam int PRIO_W = 3;
  localparam int EXC_W = 6;
  localparam int OFF_W = 10;
  localparam int NUM_SPRIO = 7;
  // --------------------------------------------------
  // Exception numbers and vector layout
  // --------------------------------------------------
  localparam logic [5:0] EXC_RESET = 6'h01;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  localparam logic [5:0] EXC_MEM = 6'h04;
  localparam logic [5:0] EXC_BUS = 6'h05;
  localparam logic [5:0] EXC_USAGE = 6'h06;
  localparam logic [5:0] EXC_SVC = 6'h0B;
  localparam logic [5:0] EXC_DEBUG = 6'h0C;
  localparam logic [5:0] EXC_DEFER = 6'h0E;
  localparam logic [5:0] EXC_TICK = 6'h0F;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
  localparam logic [9:0] VEC_SP_OFF = 10'h000;
  localparam logic [15:0] SYS_RSVD_MASK = 16'h2780;
  localparam logic [31:0] FIXED_RSVD_MASK = 32'h1401_0004;
  // --------------------------------------------------
  // Priority keys (lower wins)
  // --------------------------------------------------
  localparam logic [3:0] KEY_NMI = 4'h0;
  localparam logic [3:0] KEY_HARD = 4'h1;
  localparam logic [3:0] KEY_BASE = 4'h2;
  localparam logic [3:0] KEY_NONE = 4'hF;
  // --------------------------------------------------
  // Register map
  // --------------------------------------------------
  localparam logic [11:0] REG_ENABLE = 12'h000;
  localparam logic [11:0] REG_PEND_SET = 12'h004;
  localparam logic [11:0] REG_PEND_CLR = 12'h008;
  localparam logic [11:0] REG_ACTIVE = 12'h00C;
  localparam logic [11:0] REG_PRIO0 = 12'h010;
  localparam logic [11:0] REG_PRIO7 = 12'h02C;
  localparam logic [11:0] REG_SEL_LO = 12'h030;
  localparam logic [11:0] REG_SEL_HI = 12'h034;
  localparam logic [11:0] REG_SYS_PRIO = 12'h038;
  localparam logic [11:0] REG_SYS_CTRL = 12'h03C;
  localparam logic [11:0] REG_STATUS = 12'h040;
  localparam int CTL_GROUP_LSB = 0;
  localparam int CTL_MEM_EN = 4;
  localparam int CTL_BUS_EN = 5;
  localparam int CTL_USAGE_EN = 6;
  localparam int CTL_NMI_SEL_LSB = 8;
  localparam int CTL_NMI_CONN = 15;
  localparam int CTL_DEFER_SET = 16;
  localparam logic [31:0] SYS_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_DMA = 2'h1;
  localparam logic [1:0] SRC_ROUTED = 2'h2;
  // --------------------------------------------------
  // Timing
  // --------------------------------------------------
  localparam logic [3:0] PUSH_CYCLES = 4'h8;
  localparam logic [3:0] POP_CYCLES = 4'h8;

  typedef enum logic [2:0] {
    ST_BOOT_SP, ST_BOOT_VEC, ST_IDLE, ST_PUSH, ST_POP
  } vim_state_e;

  typedef struct packed {
    logic sp_fetch;
    logic vec_valid;
    logic tail_chain;
    logic push;
    logic pop;
    logic [5:0] exc_num;
    logic [9:0] vec_off;
  } vim_core_s;
endpackage : vim_pkg

// [core/vim_ctrl.sv]
// Vectored interrupt controller with per-line source mux and APB registers
// Function
// R01 - Sixteen system exceptions, thirty-two peripheral lines
// R02 - Offset zero fetched first as stack pointer
// R03 - Reset, NMI, hard fault fixed highest
// R04 - Disabled or masked fault escalates to hard
// R05 - Bus error raises bus fault at 0x14
// R06 - System vectors at four times number
// R07 - Lines 0-31 are exceptions 16-47
// R08 - Table entries carry bit 0 set
// R09 - NMI pin selectable or disconnected
// R10 - Eight runtime-writable priority levels per line
// R11 - Grouping splits preempt and subpriority parts
// R12 - Tail-chaining and late-arrival takeover
// R13 - Hardware pushes and pops state
// R14 - Equal priority: lower vector number first
// R15 - Per-line three-way source selector
// R16 - DMA termination buses feed vectors
// R17 - Routed bus bit n feeds vector n
// R18 - Routed source reaches every vector
// R19 - Fixed sources for vectors 0-15
// R20 - Fixed sources for vectors 16-31
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module vim_ctrl #(
  parameter int NMI_PINS = 32
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_low_voltage_detect,
  input wire logic i_cache_ecc,
  input wire logic i_sleep,
  input wire logic [15:0] i_port_irq_unit,
  input wire logic i_comparators,
  input wire logic i_sc_blocks,
  input wire logic i_i2c,
  input wire logic [3:0] i_timer,
  input wire logic [4:0] i_usb,
  input wire logic i_lcd,
  input wire logic i_decimator,
  input wire logic i_hub_err,
  input wire logic i_eeprom_fault,
  input wire logic [15:0] i_dma_term_bus_low,
  input wire logic [15:0] i_dma_term_bus_high,
  input wire logic [31:0] i_routed_irq,
  input wire logic [NMI_PINS-1:0] i_nmi_pins,
  input wire logic i_bus_err_fetch,
  input wire logic i_bus_err_data,
  input wire logic i_mem_fault,
  input wire logic i_usage_fault,
  input wire logic i_svc,
  input wire logic i_debug_mon,
  input wire logic i_sys_tick,
  input wire logic i_exc_return,
  output vim_pkg::vim_core_s o_core
);
  // --------------------------------------------------
  // Functions
  // --------------------------------------------------
  function automatic logic [2:0] sys_slot(input int n);
    case (n)
      4: sys_slot = 3'h0;
      5: sys_slot = 3'h1;
      6: sys_slot = 3'h2;
      11: sys_slot = 3'h3;
      12: sys_slot = 3'h4;
      14: sys_slot = 3'h5;
      default: sys_slot = 3'h6;
    endcase
  endfunction : sys_slot

  function automatic logic [9:0] vec_off(input logic [5:0] n);
    vec_off = {2'b00, n, 2'b00};
  endfunction : vec_off

  // --------------------------------------------------
  // State
  // --------------------------------------------------
  vim_pkg::vim_state_e state_q;
  logic [31:0] enable_q;
  logic [vim_pkg::NUM_EXC-1:0] pend_q;
  logic [vim_pkg::NUM_EXC-1:0] active_q;
  logic [vim_pkg::PRIO_W-1:0] prio_q [vim_pkg::NUM_IRQ];
  logic [vim_pkg::PRIO_W-1:0] sprio_q [vim_pkg::NUM_SPRIO];
  logic [1:0] sel_q [vim_pkg::NUM_IRQ];
  logic [31:0] ctrl_q;
  logic [3:0] cnt_q;
  logic [5:0] cur_q;
  logic [9:0] off_q;
  logic nmi_lvl_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // --------------------------------------------------
  // Source selection
  // --------------------------------------------------
  logic [31:0] fixed_src;
  logic [31:0] dma_src;
  logic [31:0] irq_src;
  logic nmi_lvl;
  logic [4:0] nmi_sel;

  always_comb begin
    fixed_src = {i_eeprom_fault, i_hub_err, i_decimator, 1'b0, i_lcd, 1'b0, i_usb, i_timer,
                 1'b0, i_i2c, i_sc_blocks, i_comparators, i_port_irq_unit[15],
                 i_port_irq_unit[12], i_port_irq_unit[6:0], i_sleep, 1'b0, i_cache_ecc,
                 i_low_voltage_detect}; // R19 R20
    fixed_src = fixed_src & ~vim_pkg::FIXED_RSVD_MASK; // R20
  end

  assign dma_src = {i_dma_term_bus_high, i_dma_term_bus_low}; // R16

  always_comb begin
    for (int n = 0; n < vim_pkg::NUM_IRQ; n++) begin
      if (sel_q[n] == vim_pkg::SRC_DMA) begin // R15
        irq_src[n] = dma_src[n];
      end else if (sel_q[n] == vim_pkg::SRC_ROUTED) begin
        irq_src[n] = i_routed_irq[n]; // R17 R18
      end else begin
        irq_src[n] = fixed_src[n];
      end
    end
  end

  assign nmi_sel = ctrl_q[vim_pkg::CTL_NMI_SEL_LSB +: 5];
  assign nmi_lvl = ctrl_q[vim_pkg::CTL_NMI_CONN] & i_nmi_pins[nmi_sel]; // R09

  // --------------------------------------------------
  // Priority keys and arbitration
  // --------------------------------------------------
  logic [3:0] full_key [vim_pkg::NUM_EXC];
  logic [3:0] grp_key [vim_pkg::NUM_EXC];
  logic [1:0] sub_bits;
  logic [vim_pkg::NUM_EXC-1:0] ready;
  logic [5:0] win_num;
  logic [3:0] win_full;
  logic [3:0] win_grp;
  logic [3:0] run_grp;
  logic [3:0] rest_grp;
  logic [5:0] top_act;

  assign sub_bits = ctrl_q[vim_pkg::CTL_GROUP_LSB +: 2];

  always_comb begin
    for (int n = 0; n < vim_pkg::NUM_EXC; n++) begin
      logic [2:0] p;
      p = (n >= vim_pkg::NUM_SYS) ? prio_q[n - vim_pkg::NUM_SYS] : sprio_q[sys_slot(n)]; // R10
      if (n == int'(vim_pkg::EXC_NMI)) begin
        full_key[n] = vim_pkg::KEY_NMI; // R03
        grp_key[n] = vim_pkg::KEY_NMI;
      end else if (n == int'(vim_pkg::EXC_HARD)) begin
        full_key[n] = vim_pkg::KEY_HARD; // R03
        grp_key[n] = vim_pkg::KEY_HARD;
      end else begin
        full_key[n] = vim_pkg::KEY_BASE + {1'b0, p};
        grp_key[n] = vim_pkg::KEY_BASE + {1'b0, p >> sub_bits}; // R11
      end
    end
  end

  assign ready = pend_q & {enable_q, ~vim_pkg::SYS_RSVD_MASK} & ~active_q; // R01 R06

  always_comb begin
    win_num = 6'h00;
    win_full = vim_pkg::KEY_NONE;
    win_grp = vim_pkg::KEY_NONE;
    for (int n = 0; n < vim_pkg::NUM_EXC; n++) begin
      if (ready[n] && full_key[n] < win_full) begin // R14
        win_num = n[5:0];
        win_full = full_key[n];
        win_grp = grp_key[n];
      end
    end
  end

  always_comb begin
    run_grp = vim_pkg::KEY_NONE;
    rest_grp = vim_pkg::KEY_NONE;
    top_act = 6'h00;
    for (int n = 0; n < vim_pkg::NUM_EXC; n++) begin
      if (active_q[n] && full_key[n] < run_grp) begin
        run_grp = full_key[n];
        top_act = n[5:0];
      end
    end
    run_grp = vim_pkg::KEY_NONE;
    for (int n = 0; n < vim_pkg::NUM_EXC; n++) begin
      if (active_q[n] && grp_key[n] < run_grp) begin
        run_grp = grp_key[n];
      end
      if (active_q[n] && n[5:0] != top_act && grp_key[n] < rest_grp) begin
        rest_grp = grp_key[n];
      end
    end
  end

  logic preempt;
  logic chain;
  logic late;
  assign preempt = (win_full != vim_pkg::KEY_NONE) && (win_grp < run_grp); // R11
  assign chain = (win_full != vim_pkg::KEY_NONE) && (win_grp < rest_grp); // R12
  assign late = (win_full != vim_pkg::KEY_NONE) && (win_grp < grp_key[cur_q]); // R12

  // --------------------------------------------------
  // Fault arrival and escalation
  // --------------------------------------------------
  logic [vim_pkg::NUM_EXC-1:0] set_ev;
  logic mem_esc;
  logic bus_esc;
  logic usage_esc;
  logic bus_ev;

  assign bus_ev = i_bus_err_fetch | i_bus_err_data; // R05
  assign mem_esc = !ctrl_q[vim_pkg::CTL_MEM_EN] || grp_key[vim_pkg::EXC_MEM] >= run_grp; // R04
  assign bus_esc = !ctrl_q[vim_pkg::CTL_BUS_EN] || grp_key[vim_pkg::EXC_BUS] >= run_grp;
  assign usage_esc = !ctrl_q[vim_pkg::CTL_USAGE_EN] || grp_key[vim_pkg::EXC_USAGE] >= run_grp;

  logic apb_wr;
  logic apb_setup;
  assign apb_wr = i_psel & i_penable & i_pwrite;
  assign apb_setup = i_psel & ~i_penable;

  always_comb begin
    set_ev = '0;
    set_ev[vim_pkg::NUM_EXC-1:vim_pkg::NUM_SYS] = irq_src; // R07
    set_ev[vim_pkg::EXC_NMI] = nmi_lvl & ~nmi_lvl_q;
    set_ev[vim_pkg::EXC_MEM] = i_mem_fault & ~mem_esc;
    set_ev[vim_pkg::EXC_BUS] = bus_ev & ~bus_esc; // R05
    set_ev[vim_pkg::EXC_USAGE] = i_usage_fault & ~usage_esc;
    set_ev[vim_pkg::EXC_HARD] = (i_mem_fault & mem_esc) | (bus_ev & bus_esc)
                              | (i_usage_fault & usage_esc); // R04
    set_ev[vim_pkg::EXC_SVC] = i_svc;
    set_ev[vim_pkg::EXC_DEBUG] = i_debug_mon;
    set_ev[vim_pkg::EXC_TICK] = i_sys_tick;
    set_ev[vim_pkg::EXC_DEFER] = apb_wr && i_paddr == vim_pkg::REG_SYS_CTRL
                               && i_pwdata[vim_pkg::CTL_DEFER_SET];
    if (apb_wr && i_paddr == vim_pkg::REG_PEND_SET) begin
      set_ev[vim_pkg::NUM_EXC-1:vim_pkg::NUM_SYS] = irq_src | i_pwdata;
    end
  end

  // --------------------------------------------------
  // Entry and exit sequencing
  // --------------------------------------------------
  logic take;
  assign take = state_q == vim_pkg::ST_PUSH && cnt_q == vim_pkg::PUSH_CYCLES - 4'h1;
  logic tail_now;
  assign tail_now = state_q == vim_pkg::ST_IDLE && i_exc_return && active_q != '0 && chain;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_q <= vim_pkg::ST_BOOT_SP;
      cnt_q <= 4'h0;
      cur_q <= vim_pkg::EXC_RESET;
      off_q <= vim_pkg::VEC_SP_OFF;
    end else begin
      case (state_q)
        vim_pkg::ST_BOOT_SP: begin
          state_q <= vim_pkg::ST_BOOT_VEC; // R02
          off_q <= vec_off(vim_pkg::EXC_RESET);
        end
        vim_pkg::ST_BOOT_VEC: begin
          state_q <= vim_pkg::ST_IDLE;
        end
        vim_pkg::ST_IDLE: begin
          if (i_exc_return && active_q != '0) begin
            if (chain) begin
              cur_q <= win_num; // R12
              off_q <= vec_off(win_num); // R06 R07
            end else begin
              state_q <= vim_pkg::ST_POP; // R13
              cnt_q <= 4'h0;
            end
          end else if (preempt) begin
            state_q <= vim_pkg::ST_PUSH; // R13
            cnt_q <= 4'h0;
            cur_q <= win_num;
            off_q <= vec_off(win_num);
          end
        end
        vim_pkg::ST_PUSH: begin
          cnt_q <= cnt_q + 4'h1;
          if (take) begin
            state_q <= vim_pkg::ST_IDLE;
          end else if (late) begin
            cur_q <= win_num; // R12
            off_q <= vec_off(win_num);
          end
        end
        vim_pkg::ST_POP: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == vim_pkg::POP_CYCLES - 4'h1) begin
            state_q <= vim_pkg::ST_IDLE;
          end
        end
        default: state_q <= vim_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------
  // Pending and active flags
  // --------------------------------------------------
  logic [vim_pkg::NUM_EXC-1:0] pend_clr;
  always_comb begin
    pend_clr = '0;
    if (take || tail_now) begin
      pend_clr[take ? cur_q : win_num] = 1'b1;
    end
    if (apb_wr && i_paddr == vim_pkg::REG_PEND_CLR) begin
      pend_clr[vim_pkg::NUM_EXC-1:vim_pkg::NUM_SYS] = i_pwdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      pend_q <= '0;
      nmi_lvl_q <= 1'b0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | set_ev;
      nmi_lvl_q <= nmi_lvl;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      active_q <= '0;
    end else if (take) begin
      active_q[cur_q] <= 1'b1;
    end else if (state_q == vim_pkg::ST_IDLE && i_exc_return && active_q != '0) begin
      active_q[top_act] <= 1'b0;
      if (chain) begin
        active_q[win_num] <= 1'b1; // R12
      end
    end
  end

  // --------------------------------------------------
  // Register file
  // --------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      enable_q <= 32'h0000_0000;
      ctrl_q <= vim_pkg::SYS_CTRL_RST;
      for (int n = 0; n < vim_pkg::NUM_IRQ; n++) begin
        prio_q[n] <= 3'h0;
        sel_q[n] <= vim_pkg::SRC_FIXED;
      end
      for (int n = 0; n < vim_pkg::NUM_SPRIO; n++) begin
        sprio_q[n] <= 3'h0;
      end
    end else if (apb_wr) begin
      if (i_paddr == vim_pkg::REG_ENABLE) begin
        enable_q <= i_pwdata;
      end else if (i_paddr >= vim_pkg::REG_PRIO0 && i_paddr <= vim_pkg::REG_PRIO7
                   && i_paddr[1:0] == 2'h0) begin
        for (int b = 0; b < 4; b++) begin
          prio_q[{i_paddr[4:2] - 3'h4, b[1:0]}] <= i_pwdata[b*8 +: 3]; // R10
        end
      end else if (i_paddr == vim_pkg::REG_SEL_LO || i_paddr == vim_pkg::REG_SEL_HI) begin
        for (int b = 0; b < 16; b++) begin
          sel_q[{i_paddr[2], b[3:0]}] <= i_pwdata[b*2 +: 2]; // R15
        end
      end else if (i_paddr == vim_pkg::REG_SYS_PRIO) begin
        for (int b = 0; b < vim_pkg::NUM_SPRIO; b++) begin
          sprio_q[b] <= i_pwdata[b*4 +: 3];
        end
      end else if (i_paddr == vim_pkg::REG_SYS_CTRL) begin
        ctrl_q <= i_pwdata & 32'h0000_9F73;
      end
    end
  end

  logic [31:0] rd;
  logic rd_err;
  always_comb begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    if (i_paddr == vim_pkg::REG_ENABLE) begin
      rd = enable_q;
    end else if (i_paddr == vim_pkg::REG_PEND_SET || i_paddr == vim_pkg::REG_PEND_CLR) begin
      rd = pend_q[vim_pkg::NUM_EXC-1:vim_pkg::NUM_SYS];
    end else if (i_paddr == vim_pkg::REG_ACTIVE) begin
      rd = active_q[vim_pkg::NUM_EXC-1:vim_pkg::NUM_SYS];
    end else if (i_paddr >= vim_pkg::REG_PRIO0 && i_paddr <= vim_pkg::REG_PRIO7
                 && i_paddr[1:0] == 2'h0) begin
      for (int b = 0; b < 4; b++) begin
        rd[b*8 +: 3] = prio_q[{i_paddr[4:2] - 3'h4, b[1:0]}];
      end
    end else if (i_paddr == vim_pkg::REG_SEL_LO || i_paddr == vim_pkg::REG_SEL_HI) begin
      for (int b = 0; b < 16; b++) begin
        rd[b*2 +: 2] = sel_q[{i_paddr[2], b[3:0]}];
      end
    end else if (i_paddr == vim_pkg::REG_SYS_PRIO) begin
      for (int b = 0; b < vim_pkg::NUM_SPRIO; b++) begin
        rd[b*4 +: 3] = sprio_q[b];
      end
    end else if (i_paddr == vim_pkg::REG_SYS_CTRL) begin
      rd = ctrl_q;
    end else if (i_paddr == vim_pkg::REG_STATUS) begin
      rd = {pend_q[15:0], 2'b00, win_num, 1'b0, 1'(active_q != '0), cur_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= i_pwrite ? 32'h0000_0000 : rd;
      pslverr_q <= rd_err;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_q & i_psel & i_penable;

  // --------------------------------------------------
  // Core side
  // --------------------------------------------------
  always_comb begin
    o_core.sp_fetch = state_q == vim_pkg::ST_BOOT_SP; // R02
    o_core.vec_valid = state_q == vim_pkg::ST_BOOT_VEC || take || tail_now;
    o_core.tail_chain = tail_now; // R12
    o_core.push = state_q == vim_pkg::ST_PUSH; // R13
    o_core.pop = state_q == vim_pkg::ST_POP; // R13
    o_core.exc_num = tail_now ? win_num : cur_q;
    o_core.vec_off = tail_now ? vec_off(win_num) : off_q;
  end
endmodule : vim_ctrl

// [tb/vim_ctrl_props.sv]
// Assertion checker on the ports of the vectored interrupt mux
`timescale 1ns/1ps
module vim_ctrl_props (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic o_pslverr,
  input wire vim_pkg::vim_core_s o_core
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  sequence seq_boot;
    o_core.sp_fetch && o_core.vec_off == vim_pkg::VEC_SP_OFF ##1 o_core.vec_valid &&
      o_core.exc_num == vim_pkg::EXC_RESET && o_core.vec_off == 10'h004;
  endsequence
  sequence seq_push;
    (o_core.push && !o_core.vec_valid) [*7] ##1 (o_core.push && o_core.vec_valid);
  endsequence
  sequence seq_pop;
    o_core.pop [*8] ##1 !o_core.pop;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_BOOT: assert property ($rose(i_reset_n) |-> seq_boot)
    else $error("boot fetch order wrong");
  AST_SP_ONLY: assert property (o_core.sp_fetch |-> !$past(i_reset_n))
    else $error("stack pointer fetch outside boot");
  AST_VEC_OFF: assert property (o_core.vec_valid |->
    o_core.vec_off == {2'b00, o_core.exc_num, 2'b00})
    else $error("vector offset not four times number");
  AST_NO_RSVD: assert property (o_core.vec_valid |->
    o_core.exc_num inside {[1:6], 11, 12, [14:47]})
    else $error("reserved exception number issued");
  AST_PUSH: assert property ($rose(o_core.push) |-> seq_push)
    else $error("state push length wrong");
  AST_POP: assert property ($rose(o_core.pop) |-> seq_pop)
    else $error("state pop length wrong");
  AST_TAIL: assert property (o_core.tail_chain |->
    o_core.vec_valid && !o_core.push && !o_core.pop)
    else $error("tail chain with state save");
  AST_VEC_ONCE: assert property (o_core.vec_valid |=> !o_core.vec_valid)
    else $error("vector strobe too long");
  AST_SLVERR: assert property (i_paddr[1:0] == 2'b00 |->
    o_pslverr == (i_psel && i_penable && i_paddr > vim_pkg::REG_STATUS))
    else $error("slave error wrong");
endmodule : vim_ctrl_props

bind vim_ctrl vim_ctrl_props u_vim_ctrl_props (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pslverr(o_pslverr),
  .o_core(o_core));

// [tb/vim_core_model.sv]
// Behavioural core that returns after a delay from the latest vectored handler other than reset
`timescale 1ns/1ps
module vim_core_model #(
  parameter int RET_DLY = 6
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire vim_pkg::vim_core_s i_core,
  output logic o_exc_return
);
  // ----------------------------------------
  // Handler return
  // ----------------------------------------
  int cnt_q;
  logic [31:0] hnd_addr;
  assign hnd_addr = {22'h0, i_core.vec_off} | 32'h1;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cnt_q <= 0;
      o_exc_return <= 1'b0;
    end else begin
      o_exc_return <= (cnt_q == 1);
      if (i_core.vec_valid && hnd_addr[0] && i_core.exc_num != vim_pkg::EXC_RESET) begin
        cnt_q <= RET_DLY;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule : vim_core_model

// [tb/vim_ctrl_bench.sv]
// Self-checking bench of the vectored interrupt mux
`timescale 1ns/1ps
module vim_ctrl_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [31:0] FX_MAP = 32'hEBFE_FFFB;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] fx = 32'h0;
  logic [31:0] dma = 32'h0;
  logic [31:0] rt = 32'h0;
  logic [31:0] nmi = 32'h0;
  logic [6:0] ev = 7'h00;
  logic [31:0] prd;
  logic [31:0] rdv;
  logic pready;
  logic slverr;
  logic erv;
  logic exc_ret;
  vim_pkg::vim_core_s core;
  int err_total = 0;
  int check_count = 0;
  vim_ctrl u_vim_ctrl (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(pready), .o_pslverr(slverr), .i_low_voltage_detect(fx[0]),
    .i_cache_ecc(fx[1]), .i_sleep(fx[3]), .i_comparators(fx[13]),
    .i_port_irq_unit({fx[12], 2'h0, fx[11], 5'h00, fx[10:4]}), .i_sc_blocks(fx[14]),
    .i_i2c(fx[15]), .i_timer(fx[20:17]), .i_usb(fx[25:21]), .i_lcd(fx[27]),
    .i_decimator(fx[29]), .i_hub_err(fx[30]), .i_eeprom_fault(fx[31]),
    .i_dma_term_bus_low(dma[15:0]), .i_dma_term_bus_high(dma[31:16]), .i_routed_irq(rt),
    .i_nmi_pins(nmi), .i_bus_err_fetch(ev[0]), .i_bus_err_data(ev[1]), .i_mem_fault(ev[2]),
    .i_usage_fault(ev[3]), .i_svc(ev[4]), .i_debug_mon(ev[5]), .i_sys_tick(ev[6]),
    .i_exc_return(exc_ret), .o_core(core));
  vim_core_model u_vim_core_model (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_core(core),
    .o_exc_return(exc_ret));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1) @(posedge i_mclk);
    rdv = prd;
    erv = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task pulse(input logic [31:0] f, input logic [31:0] d, input logic [31:0] r,
    input logic [6:0] e);
    @(posedge i_mclk);
    fx <= f;
    dma <= d;
    rt <= r;
    ev <= e;
    @(posedge i_mclk);
    fx <= '0;
    dma <= '0;
    rt <= '0;
    ev <= '0;
  endtask : pulse
  task take(input logic [5:0] e, input logic t);
    int n;
    n = 0;
    @(negedge i_mclk);
    while (core.vec_valid !== 1'b1 && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    chk(core.vec_valid, 1'b1);
    chk(core.exc_num, e);
    chk(core.vec_off, {e, 2'b00});
    chk(core.tail_chain, t);
  endtask : take
  task wait_pop;
    int n;
    n = 0;
    while (core.pop !== 1'b1 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    while (core.pop === 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
  endtask : wait_pop
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_boot;
    logic [10:0] pv;
    int n;
    pv = '0;
    n = 0;
    @(negedge i_mclk);
    while (core.vec_valid !== 1'b1 && n < 5) begin
      pv = {core.sp_fetch, core.vec_off};
      @(negedge i_mclk);
      n++;
    end
    chk(pv, {1'b1, vim_pkg::VEC_SP_OFF});
    chk(core.exc_num, 6'h01);
    chk(core.vec_off, 10'h004);
  endtask : t_boot
  task t_apb;
    apb(1'b0, 12'h044, 32'h0);
    chk(erv, 1'b1);
    chk(rdv, 32'h0);
    apb(1'b1, vim_pkg::REG_PRIO0, 32'h0706_0504);
    apb(1'b0, vim_pkg::REG_PRIO0, 32'h0);
    chk(rdv, 32'h0706_0504);
    apb(1'b1, vim_pkg::REG_PRIO0, 32'h0);
    apb(1'b1, vim_pkg::REG_ENABLE, 32'hFFFF_FFFF);
  endtask : t_apb
  task t_fixed;
    for (int n = 0; n < 32; n++) begin
      if (FX_MAP[n]) begin
        pulse(32'h1 << n, '0, '0, '0);
        take(6'(16 + n), 1'b0);
        wait_pop();
      end
    end
  endtask : t_fixed
  task t_src;
    logic [31:0] m;
    logic [31:0] o;
    for (int s = 1; s < 3; s++) begin
      m = (s == 1) ? 32'h5555_5555 : 32'hAAAA_AAAA;
      apb(1'b1, vim_pkg::REG_SEL_LO, m);
      apb(1'b1, vim_pkg::REG_SEL_HI, m);
      for (int n = 0; n < 32; n++) begin
        m = 32'h1 << n;
        o = 32'h1 << (31 - n);
        pulse(o, (s == 1) ? m : o, (s == 1) ? o : m, '0);
        take(6'(16 + n), 1'b0);
        wait_pop();
      end
    end
    apb(1'b1, vim_pkg::REG_SEL_LO, 32'h0);
    apb(1'b1, vim_pkg::REG_SEL_HI, 32'h0);
  endtask : t_src
  task t_order;
    apb(1'b1, vim_pkg::REG_PEND_SET, 32'h0000_0028);
    take(6'h13, 1'b0);
    take(6'h15, 1'b1);
    wait_pop();
    apb(1'b1, vim_pkg::REG_PRIO0, 32'h0700_0000);
    apb(1'b1, vim_pkg::REG_PEND_SET, 32'h0000_0008);
    apb(1'b1, vim_pkg::REG_PEND_SET, 32'h0000_0020);
    take(6'h15, 1'b0);
    take(6'h13, 1'b1);
    wait_pop();
    apb(1'b1, vim_pkg::REG_SYS_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, vim_pkg::REG_SYS_CTRL, 32'h0);
    chk(rdv, 32'h0000_9F73);
    take(vim_pkg::EXC_DEFER, 1'b0);
    wait_pop();
    apb(1'b1, vim_pkg::REG_PEND_SET, 32'h0000_0008);
    apb(1'b1, vim_pkg::REG_PEND_SET, 32'h0000_0020);
    take(6'h13, 1'b0);
    take(6'h15, 1'b1);
    wait_pop();
    apb(1'b1, vim_pkg::REG_PRIO0, 32'h0);
  endtask : t_order
  task t_sys;
    logic [5:0] ex [7];
    ex = '{6'h05, 6'h05, 6'h03, 6'h03, 6'h0B, 6'h0C, 6'h0F};
    apb(1'b1, vim_pkg::REG_SYS_CTRL, 32'h0000_0020);
    for (int i = 0; i < 7; i++) begin
      pulse('0, '0, '0, 7'(1 << i));
      take(ex[i], 1'b0);
      wait_pop();
    end
    apb(1'b1, vim_pkg::REG_SYS_CTRL, 32'h0000_8720);
    @(posedge i_mclk);
    nmi <= 32'h0000_0080;
    take(vim_pkg::EXC_NMI, 1'b0);
    @(posedge i_mclk);
    nmi <= '0;
    wait_pop();
  endtask : t_sys
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (10000) @(posedge i_mclk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    t_boot();
    t_apb();
    t_fixed();
    t_src();
    t_order();
    t_sys();
    end_sim();
  end
endmodule : vim_ctrl_bench
